// ---- vbfc_acq.sv ----
// Acquisition interface: framing check, buffer writes, parameter fetch
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - VPS lines are received only on an error-free fixed VPS code.
// - Masked check: all bits not marked don't-care must match.
// - WSS lines are received only on an error-free fixed WSS code.
// - A two-bit line parameter picks the framing check per line.
// - Service type WSS forces the WSS check whatever the select.
// - Events set sticky flags; software clears them before the next.
// - Field parameters are fetched from the buffer after each locked V sync while acquisition is on.
// - Line parameters are fetched from memory after each H sync inside the line window while under the line budget.
// - Buffer base comes from the low four control bits.
// - Nine field bytes, then one 47-byte slot per line.
// - After 18 lines, or 314 in full mode, wait for a locked V pulse.
// - Clearing the acquisition-on bit halts at once.
// - Setting it again resumes at the next V pulse if sync is stable.
// - Field status is written once per field as a snapshot.
// - Byte code check allows zero or one bit error per line setting.
// - Normal mode takes lines 6 to 23, full mode 6 to field end.
// - After a match, serial bits become bytes written to memory.
module vbfc_acq (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic [1:0] sfr_sel_in,
   input wire logic sfr_wr_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   input wire logic vsync_in,
   input wire logic hsync_in,
   input wire logic [8:0] line_num_in,
   input wire logic sync_stable_in,
   input wire logic bit_in,
   input wire logic bit_valid_in,
   input wire logic line_end_in,
   input wire logic [7:0] field_status_in,
   input wire logic [11:0] lines_per_field_in,
   input wire logic [6:0] irq_event_a_in,
   input wire logic [7:0] irq_event_b_in,
   output logic [15:0] mem_addr_out,
   output logic mem_rd_out,
   output logic mem_wr_out,
   output logic [7:0] mem_wdata_out,
   input wire logic [7:0] mem_rdata_in,
   output logic [15:0] data_rate_step_out,
   output logic [7:0] line_service_select_out,
   output logic [7:0] line_length_divider_out,
   output logic [7:0] compensation_enables_out,
   output logic irq_a_out,
   output logic irq_b_out
);
   typedef struct packed {
      vbfc_pkg::vbfc_state_t state;
      logic acq_on;
      logic [3:0] base;
      logic full;
      logic [7:0] irq_a;
      logic [7:0] irq_b;
      logic irq_a_any;
      logic irq_b_any;
      logic [7:0] rdata;
      logic [15:0] mcode;
      logic [15:0] mask;
      logic [7:0] bcode;
      logic [7:0] comp;
      logic [15:0] drs;
      logic [7:0] svc;
      logic [7:0] len;
      logic [15:0] slot;
      logic [8:0] lines;
      logic [5:0] idx;
      logic rdv;
      logic [15:0] shreg;
      logic [4:0] nbits;
      logic [7:0] byte_sh;
      logic [2:0] bitcnt;
      logic [5:0] nbytes;
      logic [5:0] parity_error_count;
      logic line_data_error;
      logic framing_match_ok;
      logic [15:0] mem_addr;
      logic mem_rd;
      logic mem_wr;
      logic [7:0] mem_wdata;
   } vbfc_regs_t;
   vbfc_regs_t q, d;

   function automatic logic in_window(input logic [8:0] ln,
                                      input logic fullm);
      return ln >= vbfc_pkg::FIRST_LINE &&
             (fullm || ln <= vbfc_pkg::LAST_LINE_SERVICE_TYPE);
   endfunction

   logic match;
   logic full_mode;
   logic [8:0] max_lines;
   logic [15:0] base_addr;
   logic [7:0] fstat;
   logic [1:0] acq_state;
   logic [7:0] new_byte;
   logic ctrl_wr;

   assign full_mode = q.comp[vbfc_pkg::FULL_BIT];
   assign max_lines = full_mode ? vbfc_pkg::MAX_LINES_FULL
                                : vbfc_pkg::MAX_LINES_SERVICE_TYPE;
   // Coarse 4 KB granules hold a normal-mode buffer; a 314-line full-mode buffer runs past one granule
   assign base_addr = {q.base, 12'h000};
   assign fstat = {field_status_in[7:6], sync_stable_in,
                   field_status_in[4:0]};
   assign new_byte = {bit_in, q.byte_sh[7:1]};
   assign ctrl_wr = sfr_wr_in && sfr_sel_in == vbfc_pkg::SFR_BUF_CTRL;

   always_comb begin
      if (q.state == vbfc_pkg::S_IDLE) acq_state = vbfc_pkg::ACQST_IDLE;
      else if (q.state == vbfc_pkg::S_ARM)
         acq_state = q.full ? vbfc_pkg::ACQST_FULL : vbfc_pkg::ACQST_WAIT;
      else acq_state = vbfc_pkg::ACQST_RUN;
   end

   vbfc_fc_check u_check (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .shift_in(q.shreg),
      .nbits_in(q.nbits),
      .sel_in(q.svc[vbfc_pkg::FRAMING_CHECK_SELECT_MSB:vbfc_pkg::FRAMING_CHECK_SELECT_LSB]),
      .svc_in(q.svc[vbfc_pkg::SVC_MSB:vbfc_pkg::SVC_LSB]),
      .tol_in(q.svc[vbfc_pkg::TOL_BIT]),
      .byte_code_in(q.bcode),
      .mcode_in(q.mcode),
      .mask_in(q.mask),
      .match_out(match)
   );

   always_comb begin
      d = q;
      d.mem_rd = 1'b0;
      d.mem_wr = 1'b0;
      d.rdv = q.mem_rd;
      // Set beats clear: a flag written 0 in the event cycle stays set
      d.irq_a = q.irq_a;
      d.irq_b = q.irq_b;
      if (sfr_wr_in && sfr_sel_in == vbfc_pkg::SFR_IRQ_A)
         d.irq_a = q.irq_a & sfr_wdata_in;
      if (sfr_wr_in && sfr_sel_in == vbfc_pkg::SFR_IRQ_B)
         d.irq_b = q.irq_b & sfr_wdata_in;
      d.irq_a = d.irq_a | {1'b0, irq_event_a_in};
      d.irq_b = d.irq_b | irq_event_b_in;
      unique case (sfr_sel_in)
         vbfc_pkg::SFR_BUF_CTRL:
            d.rdata = {q.acq_on, 1'b0, acq_state, q.base};
         vbfc_pkg::SFR_IRQ_A: d.rdata = q.irq_a;
         vbfc_pkg::SFR_IRQ_B: d.rdata = q.irq_b;
         default: d.rdata = 8'h00;
      endcase

      unique case (q.state)
         vbfc_pkg::S_IDLE, vbfc_pkg::S_ARM: begin
         end
         vbfc_pkg::S_FRD: begin
            if (q.rdv) begin
               case (q.idx)
                  6'h00: d.mcode[15:8] = mem_rdata_in;
                  6'h01: d.mcode[7:0] = mem_rdata_in;
                  6'h02: d.mask[15:8] = mem_rdata_in;
                  6'h03: d.mask[7:0] = mem_rdata_in;
                  6'h04: d.bcode = mem_rdata_in;
                  default: d.comp = mem_rdata_in;
               endcase
               d.idx = q.idx + 6'h01;
               if (q.idx == vbfc_pkg::FP_READ_LAST) d.state = vbfc_pkg::S_FWR;
            end else if (!q.mem_rd) begin
               d.mem_rd = 1'b1;
               d.mem_addr = base_addr + {10'h000, q.idx};
            end
         end
         vbfc_pkg::S_FWR: begin
            // Status snapshot taken once, right after the field fetch
            d.mem_wr = 1'b1;
            d.mem_addr = base_addr + {10'h000, q.idx};
            case (q.idx)
               6'h06: d.mem_wdata = fstat;
               6'h07: d.mem_wdata = {4'h0, lines_per_field_in[11:8]};
               default: d.mem_wdata = lines_per_field_in[7:0];
            endcase
            d.idx = q.idx + 6'h01;
            if (q.idx == vbfc_pkg::FP_WRITE_LAST)
               d.state = vbfc_pkg::S_WAITH;
         end
         vbfc_pkg::S_WAITH: begin
            if (hsync_in) begin
               if (!full_mode &&
                   line_num_in == vbfc_pkg::LAST_LINE_SERVICE_TYPE + 9'h001)
                  d.irq_a[vbfc_pkg::L24_BIT] = 1'b1;
               if (in_window(line_num_in, full_mode)) begin
                  if (q.lines >= max_lines) begin
                     d.full = 1'b1;
                     d.state = vbfc_pkg::S_ARM;
                  end else begin
                     d.state = vbfc_pkg::S_LRD;
                     d.idx = 6'h00;
                  end
               end
            end
         end
         vbfc_pkg::S_LRD: begin
            if (q.rdv) begin
               case (q.idx)
                  6'h00: d.drs[15:8] = mem_rdata_in;
                  6'h01: d.drs[7:0] = mem_rdata_in;
                  6'h02: d.svc = mem_rdata_in;
                  default: d.len = mem_rdata_in;
               endcase
               d.idx = q.idx + 6'h01;
               if (q.idx == vbfc_pkg::LP_READ_LAST) begin
                  d.state = vbfc_pkg::S_HUNT;
                  d.nbytes = 6'h00;
                  d.parity_error_count = 6'h00;
                  d.line_data_error = 1'b0;
                  d.framing_match_ok = 1'b0;
                  d.bitcnt = 3'h0;
               end
            end else if (!q.mem_rd) begin
               d.mem_rd = 1'b1;
               d.mem_addr = q.slot + {10'h000, q.idx};
            end
         end
         vbfc_pkg::S_HUNT: begin
            if (line_end_in || hsync_in) d.state = vbfc_pkg::S_LWR;
            else if (match) begin
               d.state = vbfc_pkg::S_DATA;
               d.framing_match_ok = 1'b1;
            end else if (bit_valid_in) begin
               d.shreg = {q.shreg[14:0], bit_in};
               if (q.nbits != vbfc_pkg::NBITS_WORD)
                  d.nbits = q.nbits + 5'h01;
            end
         end
         vbfc_pkg::S_DATA: begin
            if (line_end_in || hsync_in) d.state = vbfc_pkg::S_LWR;
            else if (bit_valid_in) begin
               d.byte_sh = new_byte;
               d.bitcnt = q.bitcnt + 3'h1;
               if (q.bitcnt == 3'h7) begin
                  if (q.nbytes == vbfc_pkg::DATA_BYTES) d.line_data_error = 1'b1;
                  else begin
                     d.mem_wr = 1'b1;
                     d.mem_addr = q.slot + vbfc_pkg::DATA_OFS +
                                  {10'h000, q.nbytes};
                     d.mem_wdata = new_byte;
                     d.nbytes = q.nbytes + 6'h01;
                     // Odd parity expected; saturate rather than wrap
                     if (!(^new_byte) && q.parity_error_count != vbfc_pkg::PARITY_ERROR_COUNT_MAX)
                        d.parity_error_count = q.parity_error_count + 6'h01;
                  end
               end
            end
         end
         vbfc_pkg::S_LWR: begin
            d.mem_wr = 1'b1;
            d.mem_addr = q.slot + vbfc_pkg::LP_STATUS_OFS;
            d.mem_wdata = {q.parity_error_count, q.line_data_error, q.framing_match_ok};
            d.slot = q.slot + vbfc_pkg::LINE_SLOT;
            d.lines = q.lines + 9'h001;
            d.nbits = 5'h00;
            d.shreg = 16'h0000;
            d.state = vbfc_pkg::S_WAITH;
         end
         default: d.state = vbfc_pkg::S_IDLE;
      endcase

      if (vsync_in && q.state != vbfc_pkg::S_IDLE) begin
         // A V pulse without lock leaves the block waiting
         d.state = sync_stable_in ? vbfc_pkg::S_FRD
                                  : vbfc_pkg::S_ARM;
         d.idx = 6'h00;
         d.lines = 9'h000;
         d.full = 1'b0;
         d.nbits = 5'h00;
         d.slot = base_addr + vbfc_pkg::FIELD_BYTES;
      end

      if (ctrl_wr) begin
         d.acq_on = sfr_wdata_in[vbfc_pkg::ACQ_ON_BIT];
         d.base = sfr_wdata_in[3:0];
         if (!sfr_wdata_in[vbfc_pkg::ACQ_ON_BIT]) begin
            d.state = vbfc_pkg::S_IDLE;
            d.mem_rd = 1'b0;
            d.mem_wr = 1'b0;
         end else if (!q.acq_on) begin
            d.state = vbfc_pkg::S_ARM;
            d.full = 1'b0;
         end
      end
      // Summary lines are registered so the pins come from flip-flops
      d.irq_a_any = |d.irq_a;
      d.irq_b_any = |d.irq_b;
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         q <= '0;
         q.state <= vbfc_pkg::S_IDLE;
         q.acq_on <= vbfc_pkg::BUF_CTRL_RST[vbfc_pkg::ACQ_ON_BIT];
         q.base <= vbfc_pkg::BUF_CTRL_RST[3:0];
         q.irq_a <= vbfc_pkg::IRQ_RST;
         q.irq_b <= vbfc_pkg::IRQ_RST;
      end else begin
         q <= d;
      end
   end

   assign sfr_rdata_out = q.rdata;
   assign mem_addr_out = q.mem_addr;
   assign mem_rd_out = q.mem_rd;
   assign mem_wr_out = q.mem_wr;
   assign mem_wdata_out = q.mem_wdata;
   assign data_rate_step_out = q.drs;
   assign line_service_select_out = q.svc;
   assign line_length_divider_out = q.len;
   assign compensation_enables_out = q.comp;
   assign irq_a_out = q.irq_a_any;
   assign irq_b_out = q.irq_b_any;

   AST_HALT: assert property (@(posedge clock_in) disable iff (!resetn_in)
      (ctrl_wr && !sfr_wdata_in[vbfc_pkg::ACQ_ON_BIT])
      |=> (q.state == vbfc_pkg::S_IDLE && !mem_wr_out && !mem_rd_out))
      else $error("acquisition did not halt");
   AST_RESUME: assert property (@(posedge clock_in) disable iff (!resetn_in)
      (q.state == vbfc_pkg::S_ARM && vsync_in && !ctrl_wr)
      |=> (q.state == (($past(sync_stable_in)) ? vbfc_pkg::S_FRD
                                              : vbfc_pkg::S_ARM)))
      else $error("resume on V pulse wrong");
   AST_FIELD_ADDR: assert property (@(posedge clock_in) disable iff (!resetn_in)
      (q.state == vbfc_pkg::S_FRD && mem_rd_out) |->
      (mem_addr_out[15:12] == q.base && mem_addr_out[11:0] < 12'h009))
      else $error("field fetch outside field area");
   AST_LINE_CAP: assert property (@(posedge clock_in) disable iff (!resetn_in)
      $rose(q.state == vbfc_pkg::S_LRD) |-> (q.lines < max_lines))
      else $error("line taken beyond budget");
   AST_IRQ_STICKY: assert property (@(posedge clock_in) disable iff (!resetn_in)
      irq_event_b_in[0] |=> (q.irq_b[0] && irq_b_out))
      else $error("event flag lost");
   AST_LINE_FETCH: assert property (@(posedge clock_in) disable iff (!resetn_in)
      (q.state == vbfc_pkg::S_WAITH && hsync_in && !vsync_in && !ctrl_wr &&
       in_window(line_num_in, full_mode) && q.lines < max_lines)
      |=> q.state == vbfc_pkg::S_LRD ##2 (mem_addr_out == q.slot))
      else $error("line parameters not fetched");
   AST_SLOT_STEP: assert property (@(posedge clock_in) disable iff (!resetn_in)
      (q.state == vbfc_pkg::S_LWR && !vsync_in && !ctrl_wr) |=>
      (q.slot == $past(q.slot) + vbfc_pkg::LINE_SLOT &&
       mem_addr_out == $past(q.slot) + vbfc_pkg::LP_STATUS_OFS &&
       mem_wdata_out == $past({q.parity_error_count, q.line_data_error, q.framing_match_ok})))
      else $error("slot or status write wrong");
   AST_SNAPSHOT: assert property (@(posedge clock_in) disable iff (!resetn_in)
      (q.state == vbfc_pkg::S_FWR && q.idx == 6'h06 && !ctrl_wr &&
       !vsync_in) |=> (mem_wr_out && mem_wdata_out == $past(fstat)))
      else $error("field status not written");
endmodule
`default_nettype wire

// ---- vbfc_pkg.sv ----
// Shared constants and types of the framing and acquisition block
package vbfc_pkg;
   // Special function register selects
   localparam logic [1:0] SFR_BUF_CTRL = 2'h0;
   localparam logic [1:0] SFR_IRQ_A = 2'h1;
   localparam logic [1:0] SFR_IRQ_B = 2'h2;
   localparam int ACQ_ON_BIT = 7;
   localparam int L24_BIT = 7;
   localparam logic [7:0] BUF_CTRL_RST = 8'h00;
   localparam logic [7:0] IRQ_RST = 8'h00;
   // Buffer layout
   localparam logic [15:0] FIELD_BYTES = 16'h0009;
   localparam logic [15:0] LINE_SLOT = 16'h002F;
   localparam logic [15:0] LP_STATUS_OFS = 16'h0004;
   localparam logic [15:0] DATA_OFS = 16'h0005;
   localparam logic [5:0] DATA_BYTES = 6'h2A;
   localparam logic [5:0] FP_READ_LAST = 6'h05;
   localparam logic [5:0] FP_WRITE_LAST = 6'h08;
   localparam logic [5:0] LP_READ_LAST = 6'h03;
   localparam logic [5:0] PARITY_ERROR_COUNT_MAX = 6'h3F;
   // Line window and line budget per field
   localparam logic [8:0] FIRST_LINE = 9'h006;
   localparam logic [8:0] LAST_LINE_SERVICE_TYPE = 9'h017;
   localparam logic [8:0] MAX_LINES_SERVICE_TYPE = 9'h012;
   localparam logic [8:0] MAX_LINES_FULL = 9'h13A;
   // Field parameter fields
   localparam int FULL_BIT = 0;
   localparam int SYNC_STABLE_BIT = 5;
   // Line parameter fields of the service select byte
   localparam int SVC_MSB = 7;
   localparam int SVC_LSB = 5;
   localparam int FRAMING_CHECK_SELECT_MSB = 4;
   localparam int FRAMING_CHECK_SELECT_LSB = 3;
   localparam int TOL_BIT = 2;
   localparam logic [2:0] SVC_WSS = 3'h3;
   localparam logic [1:0] FRAMING_CHECK_SELECT_BYTE = 2'h0;
   localparam logic [1:0] FRAMING_CHECK_SELECT_VPS = 2'h1;
   localparam logic [1:0] FRAMING_CHECK_SELECT_MASKED = 2'h2;
   // Fixed codes of the two hardwired services
   localparam logic [15:0] VPS_CODE = 16'hA55A;
   localparam logic [15:0] WSS_CODE = 16'h3C1E;
   localparam logic [4:0] NBITS_BYTE = 5'h08;
   localparam logic [4:0] NBITS_WORD = 5'h10;
   // Reported acquisition state
   localparam logic [1:0] ACQST_IDLE = 2'h0;
   localparam logic [1:0] ACQST_WAIT = 2'h1;
   localparam logic [1:0] ACQST_RUN = 2'h2;
   localparam logic [1:0] ACQST_FULL = 2'h3;
   typedef enum logic [8:0] {
      S_IDLE = 9'h001, S_ARM = 9'h002, S_FRD = 9'h004,
      S_FWR = 9'h008, S_WAITH = 9'h010, S_LRD = 9'h020,
      S_HUNT = 9'h040, S_DATA = 9'h080, S_LWR = 9'h100
   } vbfc_state_t;
endpackage

// ---- vbfc_fc_check.sv ----
// Framing code comparator with one registered match result
`timescale 1ns/1ps
`default_nettype none
module vbfc_fc_check (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic [15:0] shift_in,
   input wire logic [4:0] nbits_in,
   input wire logic [1:0] sel_in,
   input wire logic [2:0] svc_in,
   input wire logic tol_in,
   input wire logic [7:0] byte_code_in,
   input wire logic [15:0] mcode_in,
   input wire logic [15:0] mask_in,
   output logic match_out
);
   typedef struct packed {logic match;} vbfc_chk_t;
   vbfc_chk_t q, d;

   function automatic logic at_most_one(input logic [7:0] x);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) n = n + {3'h0, x[i]};
      return n <= 4'h1;
   endfunction

   logic full_word;
   logic [7:0] bdiff;
   assign full_word = nbits_in >= vbfc_pkg::NBITS_WORD;
   assign bdiff = shift_in[7:0] ^ byte_code_in;

   always_comb begin
      d.match = 1'b0;
      if (svc_in == vbfc_pkg::SVC_WSS) begin
         d.match = full_word && shift_in == vbfc_pkg::WSS_CODE;
      end else begin
         unique case (sel_in)
            vbfc_pkg::FRAMING_CHECK_SELECT_BYTE: d.match =
               nbits_in >= vbfc_pkg::NBITS_BYTE &&
               (tol_in ? at_most_one(bdiff) : bdiff == 8'h00);
            vbfc_pkg::FRAMING_CHECK_SELECT_VPS:
               d.match = full_word && shift_in == vbfc_pkg::VPS_CODE;
            vbfc_pkg::FRAMING_CHECK_SELECT_MASKED: d.match = full_word &&
               ((shift_in ^ mcode_in) & ~mask_in) == 16'h0000;
            default: d.match = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) q <= '0;
      else q <= d;
   end
   assign match_out = q.match;

   AST_VPS_EXACT: assert property (@(posedge clock_in) disable iff (!resetn_in)
      (svc_in != vbfc_pkg::SVC_WSS && sel_in == vbfc_pkg::FRAMING_CHECK_SELECT_VPS &&
       full_word) |=> (match_out == $past(shift_in == vbfc_pkg::VPS_CODE)))
      else $error("VPS code check wrong");
   AST_MASKED: assert property (@(posedge clock_in) disable iff (!resetn_in)
      (svc_in != vbfc_pkg::SVC_WSS && sel_in == vbfc_pkg::FRAMING_CHECK_SELECT_MASKED &&
       full_word && ((shift_in ^ mcode_in) & ~mask_in) == 16'h0000)
      |=> match_out)
      else $error("masked code not accepted");
   AST_WSS_ONLY: assert property (@(posedge clock_in) disable iff (!resetn_in)
      (svc_in == vbfc_pkg::SVC_WSS && shift_in != vbfc_pkg::WSS_CODE)
      |=> !match_out)
      else $error("WSS line matched a foreign code");
   AST_SEL_SPARE: assert property (@(posedge clock_in) disable iff (!resetn_in)
      (svc_in != vbfc_pkg::SVC_WSS && sel_in == 2'h3) |=> !match_out)
      else $error("unused select matched");
   AST_TOL_OFF: assert property (@(posedge clock_in) disable iff (!resetn_in)
      (svc_in != vbfc_pkg::SVC_WSS && sel_in == vbfc_pkg::FRAMING_CHECK_SELECT_BYTE &&
       !tol_in && bdiff != 8'h00) |=> !match_out)
      else $error("byte code matched with bit error");
endmodule
`default_nettype wire

// ---- vbfc_ram_model.sv ----
// Byte-wide memory model standing in for the controller RAM
`timescale 1ns/1ps
`default_nettype none
module vbfc_ram_model (
   input wire logic clock_in,
   input wire logic [15:0] addr_in,
   input wire logic rd_in,
   input wire logic wr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out
);
   logic [7:0] mem [0:65535];
   initial rdata_out = 8'h00;
   // Read data holds for one cycle only; it toggles otherwise so a late
   // sample never sees a stale but plausible byte
   always @(posedge clock_in) begin
      if (wr_in) begin
         mem[addr_in] <= wdata_in;
      end
      if (rd_in) begin
         rdata_out <= mem[addr_in];
      end else begin
         rdata_out <= ~rdata_out;
      end
   end
endmodule
`default_nettype wire

// ---- vbi_framing_code_acquisition_test.sv ----
// Self-checking bench of the framing and acquisition block
`timescale 1ns/1ps
`default_nettype none
module vbi_framing_code_acquisition_test;
   logic clock_in = 1'b0, resetn_in = 1'b0, wr = 1'b0, vs = 1'b0;
   logic hs = 1'b0, sync_stable = 1'b1, bit_d = 1'b0, bv = 1'b0, le = 1'b0;
   logic mrd, mwr, irqa, irqb;
   logic [1:0] sel = 2'h0;
   logic [7:0] wdata = 8'h00, rdata, mwdata, mrdata, svc_o, len_o, comp_o;
   logic [7:0] fstat = 8'h0D, evb = 8'h00, r;
   logic [6:0] eva = 7'h00;
   logic [8:0] line = 9'h000;
   logic [11:0] lpf = 12'h271;
   logic [15:0] maddr, rate;
   logic [7:0] fp [6] = '{8'h12, 8'h34, 8'h00, 8'hFF, 8'hE4, 8'hE0};
   int errors = 0, n_compared = 0, cyc = 0, nwr = 0, n0;
   always #12.5 clock_in = ~clock_in;
   vbfc_acq vbfc_acq_inst (.clock_in(clock_in), .resetn_in(resetn_in),
      .sfr_sel_in(sel), .sfr_wr_in(wr), .sfr_wdata_in(wdata),
      .sfr_rdata_out(rdata), .vsync_in(vs), .hsync_in(hs),
      .line_num_in(line), .sync_stable_in(sync_stable), .bit_in(bit_d),
      .bit_valid_in(bv), .line_end_in(le), .field_status_in(fstat),
      .lines_per_field_in(lpf), .irq_event_a_in(eva),
      .irq_event_b_in(evb), .mem_addr_out(maddr), .mem_rd_out(mrd),
      .mem_wr_out(mwr), .mem_wdata_out(mwdata), .mem_rdata_in(mrdata),
      .data_rate_step_out(rate), .line_service_select_out(svc_o),
      .line_length_divider_out(len_o), .compensation_enables_out(comp_o),
      .irq_a_out(irqa), .irq_b_out(irqb));
   vbfc_ram_model vbfc_ram_model_inst (.clock_in(clock_in),
      .addr_in(maddr), .rd_in(mrd), .wr_in(mwr), .wdata_in(mwdata),
      .rdata_out(mrdata));
   task automatic complete_run;
      if (errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clock_in);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   task automatic sfr_w(input logic [1:0] s, input logic [7:0] d);
      sel = s;
      wdata = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
   endtask
   task automatic sfr_r(input logic [1:0] s, output logic [7:0] d);
      sel = s;
      tick(1);
      d = rdata;
   endtask
   task automatic send_bit(input logic b);
      bit_d = b;
      pulse(bv);
      tick(1);
   endtask
   // Behavioural framing decision, worked from the line parameters
   function automatic logic exp_match(input logic [2:0] sv,
         input logic [1:0] fs, input logic tl, input logic [15:0] w);
      int e;
      e = $countones(w[7:0] ^ fp[4]);
      if (sv == vbfc_pkg::SVC_WSS) return w == vbfc_pkg::WSS_CODE;
      if (fs == 2'h1) return w == vbfc_pkg::VPS_CODE;
      if (fs == 2'h2) return ((w ^ 16'h1234) & ~16'h00FF) == 16'h0000;
      if (fs == 2'h0) return e == 0 || (tl && e == 1);
      return 1'b0;
   endfunction
   task automatic run_line(input int n, input logic [2:0] sv,
         input logic [1:0] fs, input logic tl, input logic [15:0] w,
         input int nb);
      logic [7:0] d;
      logic [15:0] s;
      logic m;
      s = 16'h1009 + 16'(n) * vbfc_pkg::LINE_SLOT;
      // No three ones in a row, so data bits never form the byte code
      d = 8'($urandom) & 8'h6D;
      m = exp_match(sv, fs, tl, w);
      vbfc_ram_model_inst.mem[s + 16'h0001] = 8'h10 + 8'(n);
      vbfc_ram_model_inst.mem[s + 16'h0002] = {sv, fs, tl, 2'b00};
      vbfc_ram_model_inst.mem[s + 16'h0003] = 8'h20 + 8'(n);
      line = 9'h006 + 9'(n);
      pulse(hs);
      tick(20);
      chk("service", svc_o, {sv, fs, tl, 2'b00});
      chk("rate lo", rate[7:0], 8'h10 + 8'(n));
      chk("length", len_o, 8'h20 + 8'(n));
      for (int i = nb - 1; i >= 0; i--) send_bit(w[i]);
      tick(4);
      for (int i = 0; i < 8; i++) send_bit(d[i]);
      pulse(le);
      tick(6);
      chk("status", vbfc_ram_model_inst.mem[s + 16'h0004],
         m ? {5'h00, ~^d, 2'b01} : 8'h00);
      if (m) chk("data", vbfc_ram_model_inst.mem[s + 16'h0005], d);
   endtask
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (mwr === 1'b1) nwr <= nwr + 1;
      if (cyc == 30000) begin
         errors++;
         complete_run();
      end
   end
   initial begin
      void'($urandom(32'h40F42B02));
      // Field parameters are in RAM before acquisition is enabled
      for (int i = 0; i < 6; i++) vbfc_ram_model_inst.mem[16'h1000 + 16'(i)] = fp[i];
      for (int i = 0; i < 6 * 47; i++) vbfc_ram_model_inst.mem[16'h1009 + 16'(i)] = 8'h00;
      tick(16);
      resetn_in = 1'b1;
      for (int i = 0; i < 4; i++) begin
         sfr_r(2'(i), r);
         chk("reset", r, 8'h00);
      end
      sfr_w(2'h0, 8'h81);
      sfr_r(2'h0, r);
      chk("ctrl wait", r, 8'h91);
      pulse(vs);
      tick(40);
      sfr_r(2'h0, r);
      chk("ctrl run", r, 8'hA1);
      chk("comp", comp_o, fp[5]);
      chk("fstat", vbfc_ram_model_inst.mem[16'h1006], fstat | 8'h20);
      chk("lpf hi", vbfc_ram_model_inst.mem[16'h1007], {4'h0, lpf[11:8]});
      chk("lpf lo", vbfc_ram_model_inst.mem[16'h1008], lpf[7:0]);
      run_line(0, 3'h0, 2'h0, 1'b0, 16'h00E4, 8);
      run_line(1, 3'h0, 2'h0, 1'b1, 16'h00EC, 8);
      run_line(2, 3'h0, 2'h1, 1'b0, vbfc_pkg::VPS_CODE, 16);
      run_line(3, 3'h0, 2'h2, 1'b0, 16'h12AB, 16);
      run_line(4, vbfc_pkg::SVC_WSS, 2'h0, 1'b0, vbfc_pkg::WSS_CODE, 16);
      run_line(5, 3'h0, 2'h0, 1'b0, 16'h00E5, 8);
      line = 9'h018;
      pulse(hs);
      eva = 7'h01;
      evb = 8'($urandom) | 8'h01;
      r = evb;
      tick(1);
      eva = 7'h00;
      evb = 8'h00;
      sfr_r(2'h2, wdata);
      chk("flags b", wdata, r);
      chk("irq b", {7'h00, irqb}, 8'h01);
      sfr_r(2'h1, r);
      chk("flags a", r, 8'h81);
      chk("irq a", {7'h00, irqa}, 8'h01);
      sfr_w(2'h1, 8'h00);
      sfr_r(2'h1, r);
      chk("clear a", r, 8'h00);
      chk("irq a off", {7'h00, irqa}, 8'h00);
      sfr_w(2'h0, 8'h01);
      sfr_r(2'h0, r);
      chk("ctrl off", r, 8'h01);
      n0 = nwr;
      pulse(hs);
      tick(30);
      sync_stable = 1'b0;
      sfr_w(2'h0, 8'h81);
      pulse(vs);
      tick(40);
      sfr_r(2'h0, r);
      chk("ctrl unstable", r, 8'h91);
      chk("no writes", 8'(nwr - n0), 8'h00);
      complete_run();
   end
endmodule
`default_nettype wire
